// [rtl/cfg_port_regs.svh]
// register offsets, bit positions, reset values and counts of the serial configuration port
// assumes it is included by the port module
`ifndef CFG_PORT_REGS_SVH
`define CFG_PORT_REGS_SVH
`define PAGE_REG_ADDR 5'h1F
`define PAGE_RST_VAL 8'h00
`define CFG_RST_VAL 8'h00
`define MAIN_CFG0_ADDR 5'h00
`define MAIN_CFG1_ADDR 5'h01
`define MAIN_PAGE 4'h0
`define LOCK_BIT 0
`define PLL_LOCK_BIT 7
`define LONG_MODE_BIT 7
`define NUM_PAGES 4'h9
`define REG_COUNT 288
`define MIN_CLKS_SHORT 5'h10
`define MIN_CLKS_LONG 5'h19
`define READBACK_CLKS 5'h08
`define CLK_CNT_MAX 5'h1F
`define DEV_ADDR_GND 2'h0
`define DEV_ADDR_VDD 2'h1
`define DEV_ADDR_FLOAT 2'h2
`define STRAP_SENSE_GND 2'h0
`define STRAP_SENSE_VDD 2'h3
`define STRAP_SENSE_FLOAT 2'h2
`endif

// [rtl/cfg_port_pkg.sv]
// types shared by the serial configuration port
// assumes the constants header sits beside it
package cfg_port_pkg;
    typedef struct packed {
        logic rd;
        logic [1:0] dev;
        logic [4:0] addr;
        logic [7:0] data;
    } cmd_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_FRAME = 2'h2
    } frame_st_t;
    typedef struct packed {
        logic [1:0] strap;
        logic pll;
        logic clk_act;
        logic sin;
        logic frame_n;
        logic sclk;
    } pins_t;
endpackage

// [rtl/paged_serial_config_port.sv]
// serial configuration port with paged 8-bit register file and lock control
// assumes serial clock and frame pins are slow against the core clock (several core cycles a phase)
`include "cfg_port_regs.svh"
module paged_serial_config_port (
    input wire logic CORE_CLK_IN,
    input wire logic RSTN_IN,
    input wire logic SER_CLK_IN,
    input wire logic SER_FRAME_N_IN,
    input wire logic SER_IN_IN,
    input wire logic [1:0] STRAP_SENSE_IN,
    input wire logic MAIN_CLK_ACT_IN,
    input wire logic PLL_LOCK_IN,
    output logic SER_OUT_OUT,
    output logic SER_OUT_OE_OUT,
    output logic LOCK_OUT,
    output logic LONG_MODE_OUT,
    output logic [7:0] PAGE_OUT
);
    cfg_port_pkg::pins_t sync1_ff, sync2_ff;
    logic sclk_prev_ff, frame_prev_ff;
    cfg_port_pkg::frame_st_t state_ff, nxt_state;
    logic [4:0] cnt_ff, nxt_cnt;
    logic [15:0] sh_ff, nxt_sh;
    logic [7:0] osr_ff, nxt_osr;
    logic [7:0] staged_ff, nxt_staged;
    logic [7:0] page_ff, nxt_page;
    logic [7:0] regs_ff [0:`REG_COUNT-1];
    logic [7:0] nxt_regs [0:`REG_COUNT-1];
    logic prev_mine_ff, nxt_prev_mine;
    logic prev_wr_ff, nxt_prev_wr;
    logic oe_ff, nxt_oe;
    logic out_ff, nxt_out;
    logic [1:0] dev_addr_ff, nxt_dev_addr;
    logic strap_done_ff, nxt_strap_done;
    logic sclk_rise, frame_fall, frame_rise, long_mode, lock, len_ok, mine, page_ok, wr_go;
    logic [4:0] min_clks;
    logic [8:0] idx;
    cfg_port_pkg::cmd_t cmd;

    function automatic logic [1:0] strap_dec(input logic [1:0] sense);
        unique case (sense)
            `STRAP_SENSE_VDD: strap_dec = `DEV_ADDR_VDD;
            `STRAP_SENSE_FLOAT: strap_dec = `DEV_ADDR_FLOAT;
            default: strap_dec = `DEV_ADDR_GND;
        endcase
    endfunction

    function automatic logic wr_ok(input logic lk, input logic [3:0] pg, input logic [4:0] ad);
        wr_ok = !lk || (ad == `PAGE_REG_ADDR) || (pg == `MAIN_PAGE && ad == `MAIN_CFG0_ADDR);
    endfunction

    function automatic logic [8:0] reg_idx(input logic [3:0] pg, input logic [4:0] ad);
        reg_idx = {pg, ad};
    endfunction

    assign sclk_rise = sync2_ff.sclk && !sclk_prev_ff;
    assign frame_fall = !sync2_ff.frame_n && frame_prev_ff;
    assign frame_rise = sync2_ff.frame_n && !frame_prev_ff;
    assign long_mode = regs_ff[reg_idx(`MAIN_PAGE, `MAIN_CFG1_ADDR)][`LONG_MODE_BIT];
    assign lock = regs_ff[reg_idx(`MAIN_PAGE, `MAIN_CFG0_ADDR)][`LOCK_BIT];
    assign min_clks = long_mode ? `MIN_CLKS_LONG : `MIN_CLKS_SHORT;
    assign len_ok = cnt_ff >= min_clks;
    assign cmd = cfg_port_pkg::cmd_t'(sh_ff);
    assign mine = cmd.dev == dev_addr_ff;
    assign page_ok = page_ff < {4'h0, `NUM_PAGES};
    assign idx = reg_idx(page_ff[3:0], cmd.addr);
    assign wr_go = !cmd.rd && wr_ok(lock, page_ff[3:0], cmd.addr);

    // pins pass two flops before anything looks at them; the pair has no reset, so
    // the strap level and the idle frame level are already through when reset lifts
    always_ff @(posedge CORE_CLK_IN)
    begin
        sync1_ff <= {STRAP_SENSE_IN, PLL_LOCK_IN, MAIN_CLK_ACT_IN, SER_IN_IN,
                     SER_FRAME_N_IN, SER_CLK_IN};
        sync2_ff <= sync1_ff;
    end

    // edge detectors start at the idle pin levels, so no false edge follows reset
    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            sclk_prev_ff <= 1'b0;
            frame_prev_ff <= 1'b1;
        end
        else
        begin
            sclk_prev_ff <= sync2_ff.sclk;
            frame_prev_ff <= sync2_ff.frame_n;
        end
    end

    always_comb
    begin
        logic [7:0] cur;
        cur = `CFG_RST_VAL;
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_sh = sh_ff;
        nxt_osr = osr_ff;
        nxt_staged = staged_ff;
        nxt_page = page_ff;
        nxt_regs = regs_ff;
        nxt_prev_mine = prev_mine_ff;
        nxt_prev_wr = prev_wr_ff;
        nxt_oe = oe_ff;
        nxt_out = out_ff;
        nxt_dev_addr = dev_addr_ff;
        nxt_strap_done = 1'b1;
        if (!strap_done_ff)
            nxt_dev_addr = strap_dec(sync2_ff.strap);
        unique case (state_ff)
            cfg_port_pkg::ST_IDLE:
                if (frame_fall)
                begin
                    nxt_state = cfg_port_pkg::ST_FRAME;
                    nxt_cnt = '0;
                    nxt_osr = staged_ff;
                    nxt_oe = prev_mine_ff && (!prev_wr_ff || sync2_ff.clk_act);
                end
            cfg_port_pkg::ST_FRAME:
            begin
                if (sclk_rise)
                begin
                    nxt_sh = {sh_ff[14:0], sync2_ff.sin};
                    if (cnt_ff != `CLK_CNT_MAX)
                        nxt_cnt = cnt_ff + 5'h01;
                    if (cnt_ff < `READBACK_CLKS)
                    begin
                        nxt_out = osr_ff[7];
                        nxt_osr = {osr_ff[6:0], 1'b0};
                    end
                    else if (cnt_ff == `READBACK_CLKS)
                        nxt_oe = 1'b0;
                end
                if (frame_rise)
                begin
                    nxt_state = cfg_port_pkg::ST_IDLE;
                    nxt_oe = 1'b0;
                    if (len_ok)
                    begin
                        nxt_prev_mine = mine;
                        nxt_prev_wr = !cmd.rd;
                        if (mine)
                        begin
                            if (cmd.addr == `PAGE_REG_ADDR)
                                cur = page_ff;
                            else if (page_ok)
                                cur = regs_ff[idx];
                            if (page_ok && cmd.addr == `MAIN_CFG0_ADDR
                                && page_ff[3:0] == `MAIN_PAGE)
                                cur[`PLL_LOCK_BIT] = sync2_ff.pll;
                            if (wr_go)
                            begin
                                cur = cmd.data;
                                if (cmd.addr == `PAGE_REG_ADDR)
                                    nxt_page = cmd.data;
                                else if (page_ok)
                                    nxt_regs[idx] = cmd.data;
                            end
                            nxt_staged = cur;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            state_ff <= cfg_port_pkg::ST_IDLE;
            cnt_ff <= '0;
            sh_ff <= '0;
            osr_ff <= `CFG_RST_VAL;
            staged_ff <= `CFG_RST_VAL;
            page_ff <= `PAGE_RST_VAL;
            for (int i = 0; i < `REG_COUNT; i++)
                regs_ff[i] <= `CFG_RST_VAL;
            prev_mine_ff <= 1'b0;
            prev_wr_ff <= 1'b0;
            oe_ff <= 1'b0;
            out_ff <= 1'b0;
            dev_addr_ff <= `DEV_ADDR_GND;
            strap_done_ff <= 1'b0;
            LOCK_OUT <= 1'b0;
            LONG_MODE_OUT <= 1'b0;
            PAGE_OUT <= `PAGE_RST_VAL;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            osr_ff <= nxt_osr;
            staged_ff <= nxt_staged;
            page_ff <= nxt_page;
            regs_ff <= nxt_regs;
            prev_mine_ff <= nxt_prev_mine;
            prev_wr_ff <= nxt_prev_wr;
            oe_ff <= nxt_oe;
            out_ff <= nxt_out;
            dev_addr_ff <= nxt_dev_addr;
            strap_done_ff <= nxt_strap_done;
            LOCK_OUT <= nxt_regs[reg_idx(`MAIN_PAGE, `MAIN_CFG0_ADDR)][`LOCK_BIT];
            LONG_MODE_OUT <= nxt_regs[reg_idx(`MAIN_PAGE, `MAIN_CFG1_ADDR)][`LONG_MODE_BIT];
            PAGE_OUT <= nxt_page;
        end
    end

    assign SER_OUT_OUT = out_ff;
    assign SER_OUT_OE_OUT = oe_ff;

    default clocking dc @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (!RSTN_IN);

    a_oe_in_frame: assert property (oe_ff |-> state_ff == cfg_port_pkg::ST_FRAME)
        else $error("output driven outside a frame");
    a_oe_ninth_release: assert property (state_ff == cfg_port_pkg::ST_FRAME && sclk_rise
        && cnt_ff == `READBACK_CLKS && !frame_rise |=> !oe_ff ##1 !oe_ff)
        else $error("output not released at ninth clock");
    a_short_no_effect: assert property (state_ff == cfg_port_pkg::ST_FRAME && frame_rise
        && !len_ok |=> $stable(staged_ff) && $stable(page_ff) && $stable(prev_mine_ff))
        else $error("short transaction changed state");
    a_page_write: assert property (state_ff == cfg_port_pkg::ST_FRAME && frame_rise && len_ok
        && mine && !cmd.rd && cmd.addr == `PAGE_REG_ADDR |=> page_ff == $past(cmd.data)
        ##1 PAGE_OUT == page_ff)
        else $error("page select not written");
    a_lock_blocks: assert property (state_ff == cfg_port_pkg::ST_FRAME && frame_rise && len_ok
        && mine && lock && !wr_ok(lock, page_ff[3:0], cmd.addr) && page_ok
        |=> regs_ff[$past(idx)] == $past(regs_ff[idx]))
        else $error("locked register was written");
    a_read_stages: assert property (state_ff == cfg_port_pkg::ST_FRAME && frame_rise && len_ok
        && mine && cmd.rd && page_ok && cmd.addr != `PAGE_REG_ADDR
        && cmd.addr != `MAIN_CFG0_ADDR |=> staged_ff == $past(regs_ff[idx]))
        else $error("read did not stage register");
    a_no_write_readback: assert property (state_ff == cfg_port_pkg::ST_IDLE && frame_fall
        && prev_wr_ff && !sync2_ff.clk_act |=> !oe_ff)
        else $error("write readback driven with main clock stopped");
    a_strap_decode: assert property (!strap_done_ff |=>
        dev_addr_ff == strap_dec($past(sync2_ff.strap)) ##1 $stable(dev_addr_ff))
        else $error("strap address decoded wrong");
    a_msb_first: assert property (state_ff == cfg_port_pkg::ST_FRAME && sclk_rise
        && cnt_ff == 5'h00 |=> out_ff == $past(osr_ff[7]))
        else $error("readback not msb first");
endmodule

// [dv/ser_host_model.sv]
// host side of the serial configuration link: makes serial clock, frame and data in
// assumes calls start on a falling core clock edge; all delays are whole core cycles
module ser_host_model (
    output logic sclk_out,
    output logic frame_n_out,
    output logic sdi_out,
    input wire logic sdo_in,
    input wire logic sdo_oe_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last_sdo;
    initial
    begin
        sclk_out = 1'b0;
        frame_n_out = 1'b1;
        sdi_out = 1'b0;
        last_sdo = 1'b0;
    end
    // one frame of n clocks; link clock idles low between frames
    task automatic xfer(input int n, input logic [15:0] cmd, output logic drv,
                        output logic [7:0] rb, output logic oe10);
        logic b;
        frame_n_out = 1'b0;
        #200;
        drv = sdo_oe_in;
        rb = 8'h00;
        oe10 = 1'b0;
        for (int i = 1; i <= n; i++)
        begin
            // bits ahead of the last sixteen are junk the port must drop
            sdi_out = (n - i < 16) ? cmd[n - i] : i[0];
            #80;
            if (i >= 2 && i <= 9)
            begin
                // a released line shows the inverse of its last level
                b = sdo_oe_in ? sdo_in : ~last_sdo;
                last_sdo = b;
                rb = {rb[6:0], b};
            end
            if (i == 10)
                oe10 = sdo_oe_in;
            sclk_out = 1'b1;
            #80;
            sclk_out = 1'b0;
        end
        #80;
        frame_n_out = 1'b1;
        sdi_out = ~sdi_out;
        #200;
    endtask
endmodule

// [dv/tb_paged_serial_config_port.sv]
// self-checking bench for the paged serial configuration port
// assumes the host model file is compiled before this one
module tb_paged_serial_config_port;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk;
    logic rst_n;
    logic sclk;
    logic frame_n;
    logic ser_in;
    logic main_act;
    logic pll;
    logic [1:0] strap;
    logic ser_out;
    logic sdo_oe;
    logic lock;
    logic long_mode;
    logic [7:0] page;
    int bad_count = 0;
    int comparisons = 0;
    logic [1:0] sense_tab [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
    logic [1:0] dev_tab [4] = '{2'h1, 2'h2, 2'h0, 2'h0};

    paged_serial_config_port paged_serial_config_port_i (
        .CORE_CLK_IN(core_clk),
        .RSTN_IN(rst_n),
        .SER_CLK_IN(sclk),
        .SER_FRAME_N_IN(frame_n),
        .SER_IN_IN(ser_in),
        .STRAP_SENSE_IN(strap),
        .MAIN_CLK_ACT_IN(main_act),
        .PLL_LOCK_IN(pll),
        .SER_OUT_OUT(ser_out),
        .SER_OUT_OE_OUT(sdo_oe),
        .LOCK_OUT(lock),
        .LONG_MODE_OUT(long_mode),
        .PAGE_OUT(page)
    );
    ser_host_model ser_host_model_i (
        .sclk_out(sclk),
        .frame_n_out(frame_n),
        .sdi_out(ser_in),
        .sdo_in(ser_out),
        .sdo_oe_in(sdo_oe)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic stop_test();
        if (bad_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input int n, input logic rd, input logic [4:0] addr,
                        input logic [7:0] data, input logic exp_drv, input logic [7:0] exp_rb,
                        input logic [1:0] dev = 2'h0);
        logic drv;
        logic oe10;
        logic [7:0] rb;
        @(negedge core_clk);
        ser_host_model_i.xfer(n, {rd, dev, addr, data}, drv, rb, oe10);
        chk({7'h00, drv}, {7'h00, exp_drv});
        if (exp_drv)
            chk(rb, exp_rb);
        if (n >= 10)
            chk({7'h00, oe10}, 8'h00);
    endtask

    task automatic do_reset(input logic [1:0] sense);
        @(negedge core_clk);
        rst_n = 1'b0;
        strap = sense;
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge core_clk);
    endtask

    // span is several times the frames the sequence needs
    initial
    begin
        #400000;
        bad_count++;
        stop_test();
    end

    initial
    begin
        rst_n = 1'b0;
        strap = 2'h0;
        main_act = 1'b1;
        pll = 1'b0;
        do_reset(2'h0);
        chk(page, 8'h00);
        chk({6'h00, lock, long_mode}, 8'h00);
        xfer(16, 0, 5'h05, 8'ha5, 0, 8'h00);
        xfer(20, 1, 5'h05, 8'h00, 1, 8'ha5);
        xfer(16, 0, 5'h06, 8'h3c, 1, 8'ha5);
        xfer(15, 0, 5'h05, 8'hff, 1, 8'h3c);
        xfer(16, 1, 5'h05, 8'h00, 1, 8'h3c);
        xfer(16, 0, 5'h01, 8'h80, 1, 8'ha5);
        chk({7'h00, long_mode}, 8'h01);
        xfer(24, 1, 5'h05, 8'h00, 1, 8'h80);
        xfer(25, 1, 5'h06, 8'h00, 1, 8'h80);
        xfer(25, 0, 5'h01, 8'h00, 1, 8'h3c);
        chk({7'h00, long_mode}, 8'h00);
        xfer(16, 0, 5'h1f, 8'h02, 1, 8'h00);
        chk(page, 8'h02);
        xfer(16, 0, 5'h05, 8'h77, 1, 8'h02);
        xfer(16, 1, 5'h1f, 8'h00, 1, 8'h77);
        // a page beyond storage takes no write and reads back zero
        xfer(16, 0, 5'h1f, 8'h09, 1, 8'h02);
        chk(page, 8'h09);
        xfer(16, 0, 5'h05, 8'h66, 1, 8'h09);
        xfer(16, 1, 5'h05, 8'h00, 1, 8'h66);
        xfer(16, 0, 5'h1f, 8'h00, 1, 8'h00);
        xfer(16, 1, 5'h05, 8'h00, 1, 8'h00);
        pll = 1'b1;
        xfer(16, 1, 5'h00, 8'h00, 1, 8'ha5);
        xfer(16, 0, 5'h05, 8'h11, 1, 8'h80, 2'h1);
        xfer(16, 1, 5'h05, 8'h00, 0, 8'h00);
        xfer(16, 1, 5'h00, 8'h00, 1, 8'ha5);
        xfer(16, 0, 5'h00, 8'h01, 1, 8'h80);
        chk({7'h00, lock}, 8'h01);
        xfer(16, 0, 5'h05, 8'h11, 1, 8'h01);
        xfer(16, 0, 5'h1f, 8'h00, 1, 8'ha5);
        xfer(16, 0, 5'h00, 8'h00, 1, 8'h00);
        chk({7'h00, lock}, 8'h00);
        // main clock changes only between frames, with a short settle gap
        main_act = 1'b0;
        repeat (8) @(negedge core_clk);
        xfer(16, 1, 5'h06, 8'h00, 0, 8'h00);
        xfer(16, 0, 5'h06, 8'h42, 1, 8'h3c);
        xfer(16, 1, 5'h06, 8'h00, 0, 8'h00);
        xfer(16, 1, 5'h06, 8'h00, 1, 8'h42);
        main_act = 1'b1;
        foreach (sense_tab[k])
        begin
            do_reset(sense_tab[k]);
            xfer(16, 0, 5'h05, 8'h5a, 0, 8'h00, dev_tab[k]);
            xfer(16, 1, 5'h05, 8'h00, 1, 8'h5a, dev_tab[k]);
        end
        stop_test();
    end
endmodule
